// [hw/cwosc_pkg.sv]
package cwosc_pkg;

    // ==========================================================
    // Configuration word layout
    // ==========================================================
    localparam int CFG_WIDTH = 12;
    localparam int OSC_SEL_LSB = 0;
    localparam int WDT_EN_BIT = 3;
    localparam int PGM_PROT_BIT = 4;
    localparam int UNIMP_LOW_BIT = 5;
    localparam int OSC_FREQ_BIT = 6;
    localparam int DATA_PROT_BIT = 7;
    localparam int BOR_EN_BIT = 8;
    localparam int RST_TMR_EN_BIT = 9;
    localparam int UNIMP_HIGH_LSB = 10;
    localparam logic [11:0] CFG_UNIMP_MASK = 12'hC20;
    localparam logic [11:0] CFG_ERASED_VALUE = 12'hFFF;

    // ==========================================================
    // Oscillator select codes
    // ==========================================================
    localparam logic [2:0] OSC_LP = 3'h0;
    localparam logic [2:0] OSC_XT = 3'h1;
    localparam logic [2:0] OSC_HS = 3'h2;
    localparam logic [2:0] OSC_EC = 3'h3;
    localparam logic [2:0] OSC_INTERNAL_RC_MODE_IO = 3'h4;
    localparam logic [2:0] OSC_INTERNAL_RC_MODE_CLK = 3'h5;
    localparam logic [2:0] OSC_EXTERNAL_RC_MODE_IO = 3'h6;
    localparam logic [2:0] OSC_EXTERNAL_RC_MODE_CLK = 3'h7;

    typedef enum logic [2:0]
    {
        CWOSC_MODE_LP_XTAL = 3'h0,
        CWOSC_MODE_STD_XTAL = 3'h1,
        CWOSC_MODE_HS_XTAL = 3'h2,
        CWOSC_MODE_EXT_CLK = 3'h3,
        CWOSC_MODE_INT_RC = 3'h4,
        CWOSC_MODE_EXT_RC = 3'h5
    } cwosc_mode_t;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam longint CLK_HZ = 20_000_000;
    localparam longint LONG_DELAY_US = 18_000;
    localparam longint SHORT_DELAY_US = 10;
    localparam longint LONG_DELAY_CYC = (LONG_DELAY_US * CLK_HZ + 999_999) / 1_000_000;
    localparam longint SHORT_DELAY_CYC = (SHORT_DELAY_US * CLK_HZ + 999_999) / 1_000_000;

    // ==========================================================
    // AXI4-Lite register map
    // ==========================================================
    localparam logic [3:0] REG_CONFIG_WORD = 4'h0;
    localparam logic [3:0] REG_CONTROL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CTRL_SLEEP_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : cwosc_pkg

// [hw/cwosc_decode.sv]
`timescale 1ns/100ps

module cwosc_decode
    import cwosc_pkg::*;
(
    // Raw word
    input wire logic [11:0] cfg_raw_i,
    // Decoded fields
    output logic [11:0] cfg_read_o,
    output cwosc_mode_t mode_o,
    output logic osc_pin_clkout_o,
    output logic long_delay_o,
    output logic wdt_en_o,
    output logic bor_en_o,
    output logic data_prot_o,
    output logic pgm_prot_o,
    output logic freq_8mhz_o
);

    logic [2:0] sel;

    // ==========================================================
    // Field decode
    // ==========================================================
    always_comb
    begin
        sel = cfg_raw_i[OSC_SEL_LSB +: 3];
        cfg_read_o = cfg_raw_i | CFG_UNIMP_MASK;
        wdt_en_o = cfg_raw_i[WDT_EN_BIT];
        bor_en_o = cfg_raw_i[BOR_EN_BIT];
        data_prot_o = ~cfg_raw_i[DATA_PROT_BIT];
        pgm_prot_o = ~cfg_raw_i[PGM_PROT_BIT];
        freq_8mhz_o = cfg_raw_i[OSC_FREQ_BIT];
        osc_pin_clkout_o = 1'b0;
        long_delay_o = cfg_raw_i[RST_TMR_EN_BIT];
        case (sel)
            OSC_LP, OSC_XT, OSC_HS:
            begin
                mode_o = cwosc_mode_t'(sel);
                long_delay_o = 1'b1;
            end
            OSC_EC:
            begin
                mode_o = CWOSC_MODE_EXT_CLK;
            end
            OSC_INTERNAL_RC_MODE_IO, OSC_INTERNAL_RC_MODE_CLK:
            begin
                mode_o = CWOSC_MODE_INT_RC;
                osc_pin_clkout_o = (sel == OSC_INTERNAL_RC_MODE_CLK);
            end
            OSC_EXTERNAL_RC_MODE_IO, OSC_EXTERNAL_RC_MODE_CLK:
            begin
                mode_o = CWOSC_MODE_EXT_RC;
                osc_pin_clkout_o = (sel == OSC_EXTERNAL_RC_MODE_CLK);
            end
            default:
            begin
                mode_o = CWOSC_MODE_EXT_CLK;
            end
        endcase
    end

endmodule : cwosc_decode

// [hw/cwosc_sync.sv]
`timescale 1ns/100ps

module cwosc_sync
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Reset copy
    output logic rst_n_o
);

    logic [1:0] stages;

    // Asynchronous assert, two-flop release
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stages <= 2'b00;
        end
        else
        begin
            stages <= {stages[0], 1'b1};
        end
    end

    assign rst_n_o = stages[1];

endmodule : cwosc_sync

// [hw/cwosc_top.sv]
// Overview of operation
// - Watchdog is switched off only by its fuse; software cannot disable it.
// - Crystal modes always apply the 18 ms reset-timer delay, ignoring its fuse.
// - Clock, internal RC and external RC modes use 10 us, or 18 ms if fused.
// - Sleep ends on an input-pin change, or on a watchdog time-out while the watchdog is enabled.
// - Word is 12 bits; bits 11-10 and 5 read back as one.
// - Bit 9 set enables the 18 ms reset timer; clear disables it.
// - Bit 8 set enables brown-out reset; clear disables it.
// - Bit 7 clear protects data memory; set leaves it unprotected.
// - Bit 6 set selects 8 MHz internal oscillator; clear selects 4 MHz.
// - Bit 3 set enables the watchdog; clear disables it.
// - Codes 000, 001, 010 select crystal modes, each forcing 18 ms delay.
// - Code 011 selects external clock; secondary pin is I/O, short start-up.
// - Codes 100/101 internal RC; pin I/O or clock output; short start-up.
// - Codes 110/111 external RC; pin I/O or clock output; short start-up.
// - Reset timer counts only once master clear is high, then releases reset.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps

module cwosc_top
    import cwosc_pkg::*;
#(
    parameter longint LONG_CYCLES = LONG_DELAY_CYC
)
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Nonvolatile word and pins
    input wire logic [11:0] cfg_word_i,
    input wire logic master_clear_input_i,
    input wire logic pin_change_i,
    input wire logic watchdog_timeout_i,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Device-wide settings
    output cwosc_mode_t osc_mode_o,
    output logic secondary_pin_clkout_o,
    output logic internal_osc_8mhz_o,
    output logic watchdog_enable_o,
    output logic brownout_enable_o,
    output logic data_memory_protect_o,
    output logic program_memory_protect_o,
    output logic chip_reset_o,
    output logic sleeping_o
);

    // Timer counter is 24 bits; longer delays need a wider count
    localparam longint MAX_CYCLES = 64'h0000_0000_00FF_FFFF;

    // ==========================================================
    // Parameter check
    // ==========================================================
    if (LONG_CYCLES < SHORT_DELAY_CYC || LONG_CYCLES > MAX_CYCLES)
    begin : g_bad_long
        $error("LONG_CYCLES out of range");
    end

    typedef enum logic [2:0]
    {
        CWOSC_WAIT_MASTER_CLEAR_INPUT = 3'b001,
        CWOSC_COUNT = 3'b010,
        CWOSC_RUN = 3'b100
    } cwosc_rst_t;

    typedef struct packed
    {
        cwosc_rst_t rst_state;
        logic [23:0] count;
        logic long_sel;
        logic [11:0] cfg;
        logic sleep;
        logic aw_held;
        logic [3:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        cwosc_mode_t mode;
        logic clkout;
        logic freq8;
        logic wdt;
        logic bor;
        logic dprot;
        logic pprot;
        logic awready;
        logic wready;
        logic arready;
        logic chip_rst;
    } cwosc_state_t;

    logic rst_n_sync;
    logic [11:0] cfg_read;
    cwosc_mode_t dec_mode;
    logic dec_clkout;
    logic dec_long;
    logic dec_wdt;
    logic dec_bor;
    logic dec_dprot;
    logic dec_pprot;
    logic dec_freq8;
    cwosc_state_t state;
    cwosc_state_t next_state;
    logic do_write;
    logic wdt_wake;
    logic wake_event;
    logic timer_done;

    function automatic logic [31:0] read_mux(input logic [3:0] addr, input cwosc_state_t s);
        logic [31:0] value;
        value = 32'h0000_0000;
        case (addr)
            REG_CONFIG_WORD: value = {20'h0_0000, s.cfg};
            REG_CONTROL: value = {31'h0000_0000, s.sleep};
            REG_STATUS: value = {26'h000_0000, s.mode, s.rst_state};
            default: value = 32'h0000_0000;
        endcase
        return value;
    endfunction : read_mux

    function automatic logic addr_mapped(input logic [3:0] addr);
        return addr == REG_CONFIG_WORD || addr == REG_CONTROL || addr == REG_STATUS;
    endfunction : addr_mapped

    cwosc_sync u_sync
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .rst_n_o(rst_n_sync)
    );

    cwosc_decode u_decode
    (
        .cfg_raw_i(cfg_word_i),
        .cfg_read_o(cfg_read),
        .mode_o(dec_mode),
        .osc_pin_clkout_o(dec_clkout),
        .long_delay_o(dec_long),
        .wdt_en_o(dec_wdt),
        .bor_en_o(dec_bor),
        .data_prot_o(dec_dprot),
        .pgm_prot_o(dec_pprot),
        .freq_8mhz_o(dec_freq8)
    );

    // ==========================================================
    // Wake and timer events
    // ==========================================================
    always_comb
    begin
        // The watchdog count runs outside; only its time-out arrives here
        wdt_wake = state.wdt && watchdog_timeout_i;
        wake_event = pin_change_i || wdt_wake;
        if (state.long_sel)
        begin
            timer_done = state.count == 24'(LONG_CYCLES - 1);
        end
        else
        begin
            timer_done = state.count == 24'(SHORT_DELAY_CYC - 1);
        end
    end

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb
    begin
        next_state = state;
        do_write = 1'b0;

        // Fuses are sampled while held in reset; they cannot change mid-run
        if (state.rst_state != CWOSC_RUN)
        begin
            next_state.cfg = cfg_read;
            next_state.long_sel = dec_long;
            next_state.mode = dec_mode;
            next_state.clkout = dec_clkout;
            next_state.freq8 = dec_freq8;
            next_state.wdt = dec_wdt;
            next_state.bor = dec_bor;
            next_state.dprot = dec_dprot;
            next_state.pprot = dec_pprot;
        end

        case (state.rst_state)
            CWOSC_WAIT_MASTER_CLEAR_INPUT:
            begin
                next_state.count = 24'h00_0000;
                if (master_clear_input_i)
                begin
                    next_state.rst_state = CWOSC_COUNT;
                end
            end
            CWOSC_COUNT:
            begin
                next_state.count = state.count + 24'h00_0001;
                if (!master_clear_input_i)
                begin
                    next_state.rst_state = CWOSC_WAIT_MASTER_CLEAR_INPUT;
                end
                else if (timer_done)
                begin
                    next_state.rst_state = CWOSC_RUN;
                end
            end
            CWOSC_RUN:
            begin
                if (!master_clear_input_i)
                begin
                    next_state.rst_state = CWOSC_WAIT_MASTER_CLEAR_INPUT;
                    next_state.sleep = 1'b0;
                end
            end
            default:
            begin
                next_state.rst_state = CWOSC_WAIT_MASTER_CLEAR_INPUT;
            end
        endcase

        // Wake event beats a same-cycle sleep request
        if (state.sleep && wake_event)
        begin
            next_state.sleep = 1'b0;
        end

        // AXI write channel, address and data taken in either order
        if (s_axi_awvalid_i && !state.aw_held && !state.bvalid)
        begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !state.w_held && !state.bvalid)
        begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata_i;
            next_state.w_strb = s_axi_wstrb_i;
        end
        if (state.aw_held && state.w_held && !state.bvalid)
        begin
            do_write = 1'b1;
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = addr_mapped(state.aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end

        // Only the sleep request is writable; the word itself is read-only.
        // A wake in the same cycle cancels the request so no wake is lost.
        if (do_write && state.aw_addr == REG_CONTROL && state.w_strb[0] && state.rst_state == CWOSC_RUN
            && state.w_data[CTRL_SLEEP_BIT] && master_clear_input_i && !wake_event)
        begin
            next_state.sleep = 1'b1;
        end
        if (state.bvalid && s_axi_bready_i)
        begin
            next_state.bvalid = 1'b0;
        end

        // AXI read channel
        if (s_axi_arvalid_i && !state.rvalid)
        begin
            next_state.rvalid = 1'b1;
            next_state.rdata = read_mux(s_axi_araddr_i, state);
            next_state.rresp = addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (state.rvalid && s_axi_rready_i)
        begin
            next_state.rvalid = 1'b0;
        end

        // Readies and reset flag leave flops; next values keep their old timing
        next_state.awready = !next_state.aw_held && !next_state.bvalid;
        next_state.wready = !next_state.w_held && !next_state.bvalid;
        next_state.arready = !next_state.rvalid;
        next_state.chip_rst = next_state.rst_state != CWOSC_RUN;
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge core_clk_i or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            state <= '{rst_state: CWOSC_WAIT_MASTER_CLEAR_INPUT, count: 24'h00_0000, long_sel: 1'b1,
                       cfg: CFG_ERASED_VALUE, mode: CWOSC_MODE_EXT_RC, clkout: 1'b0,
                       freq8: 1'b0, wdt: 1'b1, bor: 1'b1, dprot: 1'b0, pprot: 1'b0,
                       awready: 1'b1, wready: 1'b1, arready: 1'b1, chip_rst: 1'b1,
                       default: '0};
        end
        else
        begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign s_axi_awready_o = state.awready;
    assign s_axi_wready_o = state.wready;
    assign s_axi_bvalid_o = state.bvalid;
    assign s_axi_bresp_o = state.bresp;
    assign s_axi_arready_o = state.arready;
    assign s_axi_rvalid_o = state.rvalid;
    assign s_axi_rdata_o = state.rdata;
    assign s_axi_rresp_o = state.rresp;
    assign osc_mode_o = state.mode;
    assign secondary_pin_clkout_o = state.clkout;
    assign internal_osc_8mhz_o = state.freq8;
    assign watchdog_enable_o = state.wdt;
    assign brownout_enable_o = state.bor;
    assign data_memory_protect_o = state.dprot;
    assign program_memory_protect_o = state.pprot;
    assign chip_reset_o = state.chip_rst;
    assign sleeping_o = state.sleep;

endmodule : cwosc_top

// [test/cwosc_checker.sv]
`timescale 1ns/100ps

module cwosc_checker
    import cwosc_pkg::*;
#(
    parameter longint LONG_CYCLES = LONG_DELAY_CYC
)
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Pins
    input wire logic [11:0] cfg_word_i,
    input wire logic master_clear_input_i,
    input wire logic pin_change_i,
    input wire logic watchdog_timeout_i,
    // Settings
    input wire cwosc_mode_t osc_mode_o,
    input wire logic secondary_pin_clkout_o,
    input wire logic internal_osc_8mhz_o,
    input wire logic watchdog_enable_o,
    input wire logic brownout_enable_o,
    input wire logic data_memory_protect_o,
    input wire logic program_memory_protect_o,
    input wire logic chip_reset_o,
    input wire logic sleeping_o
);
    // ==========================================================
    // Timer length helper
    // ==========================================================
    logic [31:0] run_cnt;
    logic [31:0] next_run_cnt;
    logic [31:0] delay_exp;
    logic long_sel;

    function automatic logic [2:0] mode_of(input logic [2:0] code);
        return code[2] ? (code[1] ? CWOSC_MODE_EXT_RC : CWOSC_MODE_INT_RC) : code;
    endfunction : mode_of

    assign long_sel = (cfg_word_i[2:0] < OSC_EC) || cfg_word_i[RST_TMR_EN_BIT];
    assign delay_exp = long_sel ? 32'(LONG_CYCLES) : 32'(SHORT_DELAY_CYC);
    always_comb next_run_cnt = (chip_reset_o && master_clear_input_i) ? run_cnt + 32'h0000_0001 : 32'h0000_0000;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            run_cnt <= 32'h0000_0000;
        else
            run_cnt <= next_run_cnt;
    end

    // ==========================================================
    // Properties
    // ==========================================================
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Slack of three covers the clear-pin sampling stages
    chk_delay_length: assert property ($fell(chip_reset_o) |->
        run_cnt + 32'h0000_0003 >= delay_exp && run_cnt <= delay_exp + 32'h0000_0003)
        else $error("reset timer length wrong");
    chk_waits_clear: assert property (chip_reset_o && !master_clear_input_i |=> chip_reset_o)
        else $error("reset released while clear held");
    chk_no_early_end: assert property ($rose(master_clear_input_i) && chip_reset_o |=> chip_reset_o [*8])
        else $error("reset released too soon");
    chk_watchdog_fuse: assert property (!chip_reset_o |-> watchdog_enable_o == cfg_word_i[WDT_EN_BIT])
        else $error("watchdog enable differs from fuse");
    chk_brownout_fuse: assert property (!chip_reset_o |-> brownout_enable_o == cfg_word_i[BOR_EN_BIT])
        else $error("brownout enable differs from fuse");
    chk_protect_fuses: assert property (!chip_reset_o |->
        data_memory_protect_o != cfg_word_i[DATA_PROT_BIT] && program_memory_protect_o != cfg_word_i[PGM_PROT_BIT])
        else $error("protection differs from fuses");
    chk_freq_fuse: assert property (!chip_reset_o |-> internal_osc_8mhz_o == cfg_word_i[OSC_FREQ_BIT])
        else $error("oscillator frequency differs from fuse");
    chk_mode_map: assert property (!chip_reset_o |-> osc_mode_o == mode_of(cfg_word_i[2:0]))
        else $error("oscillator mode wrong");
    chk_clkout_map: assert property (!chip_reset_o |->
        secondary_pin_clkout_o == (cfg_word_i[2] && cfg_word_i[0]))
        else $error("secondary pin function wrong");
    chk_sleep_wake: assert property (sleeping_o && (pin_change_i || (watchdog_timeout_i && watchdog_enable_o))
        |=> !sleeping_o)
        else $error("sleep not left on wake event");
endmodule : cwosc_checker

bind cwosc_top cwosc_checker #(.LONG_CYCLES(LONG_CYCLES)) u_chk (.*);

// [test/cwosc_board.sv]
`timescale 1ns/100ps

module cwosc_board
(
    // Board control
    input wire logic clear_hold_i,
    // Pins seen by the chip
    output logic core_clk_o,
    output logic master_clear_o
);
    initial core_clk_o = 1'h0;
    // Steady 20 MHz source, inside the high-speed crystal range
    always #25 core_clk_o = ~core_clk_o;
    // Pull-up wins once nobody holds the pin low
    assign master_clear_o = !clear_hold_i;
endmodule : cwosc_board

// [test/tb.sv]
`timescale 1ns/100ps

module tb;
    import cwosc_pkg::*;
    // ==========================================================
    // Pins
    // ==========================================================
    logic core_clk_i, master_clear_input_i;
    logic rst_n_i = 1'h0, clear_hold = 1'h1, pin_change_i = 1'h0, watchdog_timeout_i = 1'h0;
    logic [11:0] cfg_word_i = 12'h000;
    logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'hF;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    cwosc_mode_t osc_mode_o;
    logic secondary_pin_clkout_o, internal_osc_8mhz_o, watchdog_enable_o, brownout_enable_o;
    logic data_memory_protect_o, program_memory_protect_o, chip_reset_o, sleeping_o;
    int n_fail = 0, checked = 0, cycles = 0;

    cwosc_top #(.LONG_CYCLES(400)) dut (.*);
    cwosc_board board (.clear_hold_i(clear_hold), .core_clk_o(core_clk_i), .master_clear_o(master_clear_input_i));

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic stop_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [2:0] exp_mode(input logic [2:0] code);
        return code[2] ? (code[1] ? CWOSC_MODE_EXT_RC : CWOSC_MODE_INT_RC) : code;
    endfunction : exp_mode

    // Readies are sampled at the falling edge, acted on at the next rising one
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic ta, tw, tk;
        tk = 1'h0;
        @(posedge core_clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        while (!tk)
        begin
            @(negedge core_clk_i);
            ta = s_axi_awready_o;
            tw = s_axi_wready_o;
            tk = s_axi_bvalid_o;
            resp = s_axi_bresp_o;
            @(posedge core_clk_i);
            if (ta) s_axi_awvalid_i <= 1'h0;
            if (tw) s_axi_wvalid_i <= 1'h0;
            if (tk) s_axi_bready_i <= 1'h0;
        end
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ta, tk;
        tk = 1'h0;
        @(posedge core_clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        while (!tk)
        begin
            @(negedge core_clk_i);
            ta = s_axi_arready_o;
            tk = s_axi_rvalid_o;
            d = s_axi_rdata_o;
            resp = s_axi_rresp_o;
            @(posedge core_clk_i);
            if (ta) s_axi_arvalid_i <= 1'h0;
            if (tk) s_axi_rready_i <= 1'h0;
        end
    endtask : axi_read

    task automatic run_cfg(input logic [11:0] c);
        int n;
        logic lng;
        logic [31:0] d;
        logic [1:0] r;
        n = 0;
        lng = (c[2:0] < OSC_EC) || c[RST_TMR_EN_BIT];
        @(posedge core_clk_i);
        rst_n_i <= 1'h0;
        clear_hold <= 1'h1;
        cfg_word_i <= c;
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'h1;
        repeat (20) @(negedge core_clk_i);
        check("held_reset", chip_reset_o, 1'h1);
        @(posedge core_clk_i);
        clear_hold <= 1'h0;
        while (chip_reset_o !== 1'h0)
        begin
            @(negedge core_clk_i);
            n++;
        end
        check("long_delay", n > 300, lng);
        check("delay_floor", n >= (lng ? 400 : SHORT_DELAY_CYC), 1'h1);
        check("watchdog", watchdog_enable_o, c[WDT_EN_BIT]);
        check("brownout", brownout_enable_o, c[BOR_EN_BIT]);
        check("data_prot", data_memory_protect_o, !c[DATA_PROT_BIT]);
        check("pgm_prot", program_memory_protect_o, !c[PGM_PROT_BIT]);
        check("osc_8mhz", internal_osc_8mhz_o, c[OSC_FREQ_BIT]);
        check("osc_mode", osc_mode_o, exp_mode(c[2:0]));
        check("clk_out", secondary_pin_clkout_o, c[2] && c[0]);
        axi_read(REG_CONFIG_WORD, d, r);
        check("cfg_read", d, {20'h0_0000, c | CFG_UNIMP_MASK});
        check("cfg_resp", r, RESP_OKAY);
        axi_read(REG_STATUS, d, r);
        check("status", d[5:0], {exp_mode(c[2:0]), 3'h4});
    endtask : run_cfg

    task automatic sleep_wake(input logic p, input logic w, input logic stay);
        logic [1:0] r;
        axi_write(REG_CONTROL, 32'h0000_0001, r);
        check("sleep_resp", r, RESP_OKAY);
        @(negedge core_clk_i);
        check("asleep", sleeping_o, 1'h1);
        @(posedge core_clk_i);
        pin_change_i <= p;
        watchdog_timeout_i <= w;
        @(posedge core_clk_i);
        pin_change_i <= 1'h0;
        watchdog_timeout_i <= 1'h0;
        @(negedge core_clk_i);
        check("after_wake", sleeping_o, stay);
    endtask : sleep_wake

    // ==========================================================
    // Sequence
    // ==========================================================
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end

    initial
    begin
        logic [1:0] r;
        logic [31:0] d;
        // Odd codes get the timer fuse, so crystal codes show it ignored
        for (int i = 0; i < 8; i++)
            run_cfg(i[0] ? (12'h2D8 | 12'(i)) : (12'h100 | 12'(i)));
        axi_write(REG_CONFIG_WORD, 32'h0000_0000, r);
        check("cfg_wr_resp", r, RESP_OKAY);
        @(negedge core_clk_i);
        check("watchdog_kept", watchdog_enable_o, 1'h1);
        axi_write(4'hC, 32'h0000_0000, r);
        check("unmapped_wr", r, RESP_SLVERR);
        axi_read(4'hC, d, r);
        check("unmapped_resp", r, RESP_SLVERR);
        check("unmapped_data", d, 32'h0000_0000);
        sleep_wake(1'h1, 1'h0, 1'h0);
        sleep_wake(1'h0, 1'h1, 1'h0);
        run_cfg(12'h104);
        sleep_wake(1'h0, 1'h1, 1'h1);
        sleep_wake(1'h1, 1'h0, 1'h0);
        stop_test();
    end
endmodule : tb
